// ---- logic/host_mode_pkg.sv ----
// Constants, encodings and field layout of the host operating-mode control block.
// Functional notes
// - 32-bit mode register, read by command 01, written by command 81.
// - Only software writes and the two resets change the remote wake enable bit.
// - Wake enable is bit 10; wake signalled when set with resume detected.
// - Wake enable never influences hardware interrupt generation.
// - Wake connected is bit 9; hardware reset clears it, software reset keeps it.
// - Operational is 10B; frame starts begin 1 ms after entering operational.
// - Hardware changes the functional state only while it holds suspend, 11B.
// - From suspend, hardware moves to resume, 01B, on downstream resume signaling.
// - Software or hardware reset puts the functional state to reset, 00B.
// - Hardware reset alone resets the root hub and drives downstream bus reset.
package host_mode_pkg;

  localparam int          REG_WIDTH      = 32;
  localparam int          CMD_WIDTH      = 8;
  localparam logic [7:0]  CMD_MODE_READ  = 8'h01;
  localparam logic [7:0]  CMD_MODE_WRITE = 8'h81;

  localparam int          BIT_WAKE_EN    = 10;
  localparam int          BIT_WAKE_CONN  = 9;
  localparam int          FS_LSB         = 6;
  localparam int          FS_MSB         = 7;
  localparam logic [31:0] MODE_RESET     = 32'h0000_0000;

  localparam int          CLK_HZ         = 50_000_000;
  localparam int          MS_PER_S       = 1000;
  localparam int          SOF_DELAY_MS   = 1;
  localparam int          BUS_RESET_MS   = 10;
  localparam int          CYCLES_PER_MS  = CLK_HZ / MS_PER_S;
  localparam int          MS_CNT_WIDTH   = 16;

  typedef enum logic [1:0] {
    bus_reset_state       = 2'b00,
    bus_resume_state      = 2'b01,
    bus_operational_state = 2'b10,
    bus_suspend_state     = 2'b11
  } func_state_t;

endpackage

// ---- logic/reset_sync.sv ----
// Two-stage release synchroniser for the asynchronous active-low reset.
`timescale 1ns/1ps
`default_nettype none
module reset_sync (
  input  wire logic clk_i,
  input  wire logic reset_n_i,
  output var  logic reset_n_o
);

  logic stage1;
  logic stage2;

  // Assertion is immediate, release waits two edges so no flop sees a runt release.
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      stage1 <= 1'b0;
      stage2 <= 1'b0;
    end else begin
      stage1 <= 1'b1;
      stage2 <= stage1;
    end
  end

  assign reset_n_o = stage2;

endmodule
`default_nettype wire

// ---- logic/tick_divider.sv ----
// Restartable divider that gives a one-cycle enable pulse every DIV clock cycles.
`timescale 1ns/1ps
`default_nettype none
module tick_divider #(
  parameter int DIV = 50_000
) (
  input  wire logic clk_i,
  input  wire logic reset_n_i,
  input  wire logic clear_i,
  input  wire logic enable_i,
  output var  logic tick_o
);

  localparam int CW = $clog2(DIV + 1);

  logic [CW-1:0] count;
  logic [CW-1:0] next_count;
  logic          next_tick;

  generate
    if (DIV < 2) begin : g_bad_div
      $error("tick_divider needs DIV of at least 2");
    end
  endgenerate

  always_comb begin
    next_count = count;
    next_tick  = 1'b0;
    if (clear_i) begin
      next_count = '0;
    end else if (enable_i) begin
      if (count == CW'(DIV - 1)) begin
        next_count = '0;
        next_tick  = 1'b1;
      end else begin
        next_count = count + 1'b1;
      end
    end
  end

  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      count  <= '0;
      tick_o <= 1'b0;
    end else begin
      count  <= next_count;
      tick_o <= next_tick;
    end
  end

endmodule
`default_nettype wire

// ---- logic/host_functional_state_control.sv ----
// Operating-mode control register and functional state sequencing of the host controller.
`timescale 1ns/1ps
`default_nettype none
module host_functional_state_control #(
  parameter int CYCLES_PER_MS = host_mode_pkg::CYCLES_PER_MS,
  parameter int BUS_RESET_MS  = host_mode_pkg::BUS_RESET_MS
) (
  input  wire logic                                  clk_i,
  input  wire logic                                  reset_n_i,
  input  wire logic                                  cmd_valid_i,
  input  wire logic [host_mode_pkg::CMD_WIDTH-1:0]   cmd_code_i,
  input  wire logic [host_mode_pkg::REG_WIDTH-1:0]   cmd_wdata_i,
  output var  logic [host_mode_pkg::REG_WIDTH-1:0]   cmd_rdata_o,
  output var  logic                                  cmd_rvalid_o,
  input  wire logic                                  soft_reset_i,
  input  wire logic                                  port_resume_i,
  input  wire logic                                  resume_detect_flag_i,
  output var  logic                                  remote_wakeup_o,
  output var  logic                                  remote_wake_enable_o,
  output var  logic                                  remote_wake_connected_o,
  output var  logic [1:0]                            host_functional_state_o,
  output var  logic                                  sof_enable_o,
  output var  logic                                  frame_start_flag_set_o,
  output var  logic                                  root_hub_reset_o,
  output var  logic                                  port_bus_reset_o
);
  import host_mode_pkg::*;

  generate
    if (CYCLES_PER_MS < 2) begin : g_bad_ms
      $error("CYCLES_PER_MS must be at least 2");
    end
    if (BUS_RESET_MS < 1 || BUS_RESET_MS >= (1 << MS_CNT_WIDTH)) begin : g_bad_bus_reset
      $error("BUS_RESET_MS must fit the millisecond counter and be at least 1");
    end
  endgenerate

  //////////////////////////////////////////////////////////////////////////////
  // Reset release and millisecond timebases.

  logic rst_n;
  logic sof_tick;
  logic bus_tick;
  logic sof_wait;
  logic sof_entry;

  reset_sync u_reset_sync (
    .clk_i     (clk_i),
    .reset_n_i (reset_n_i),
    .reset_n_o (rst_n)
  );

  tick_divider #(
    .DIV (CYCLES_PER_MS * SOF_DELAY_MS)
  ) u_sof_delay (
    .clk_i     (clk_i),
    .reset_n_i (rst_n),
    .clear_i   (sof_entry),
    .enable_i  (sof_wait),
    .tick_o    (sof_tick)
  );

  tick_divider #(
    .DIV (CYCLES_PER_MS)
  ) u_bus_reset_ms (
    .clk_i     (clk_i),
    .reset_n_i (rst_n),
    .clear_i   (1'b0),
    .enable_i  (port_bus_reset_o),
    .tick_o    (bus_tick)
  );

  //////////////////////////////////////////////////////////////////////////////
  // Operating-mode register.

  func_state_t fs;
  func_state_t next_fs;
  logic        wake_en;
  logic        next_wake_en;
  logic        wake_conn;
  logic        next_wake_conn;
  logic        wr_hit;
  logic        rd_hit;
  logic [31:0] mode_word;

  assign wr_hit = cmd_valid_i && (cmd_code_i == CMD_MODE_WRITE);
  assign rd_hit = cmd_valid_i && (cmd_code_i == CMD_MODE_READ);

  // Reserved positions are never stored, so they always read back as zero.
  always_comb begin
    mode_word                  = MODE_RESET;
    mode_word[BIT_WAKE_EN]     = wake_en;
    mode_word[BIT_WAKE_CONN]   = wake_conn;
    mode_word[FS_MSB:FS_LSB]   = fs;
  end

  // A software write has priority over the hardware suspend-to-resume move, as the
  // driver's explicit choice of state should not be overwritten in the same cycle.
  always_comb begin
    next_fs        = fs;
    next_wake_en   = wake_en;
    next_wake_conn = wake_conn;
    if (soft_reset_i) begin
      next_fs      = bus_reset_state;
      next_wake_en = 1'b0;
    end else if (wr_hit) begin
      next_fs        = func_state_t'(cmd_wdata_i[FS_MSB:FS_LSB]);
      next_wake_en   = cmd_wdata_i[BIT_WAKE_EN];
      next_wake_conn = cmd_wdata_i[BIT_WAKE_CONN];
    end else if (fs == bus_suspend_state && port_resume_i) begin
      next_fs = bus_resume_state;
    end
  end

  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      fs        <= bus_reset_state;
      wake_en   <= 1'b0;
      wake_conn <= 1'b0;
    end else begin
      fs        <= next_fs;
      wake_en   <= next_wake_en;
      wake_conn <= next_wake_conn;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Register read port.

  logic [31:0] next_rdata;
  logic        next_rvalid;

  always_comb begin
    next_rdata  = cmd_rdata_o;
    next_rvalid = 1'b0;
    if (rd_hit) begin
      next_rdata  = mode_word;
      next_rvalid = 1'b1;
    end
  end

  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      cmd_rdata_o  <= MODE_RESET;
      cmd_rvalid_o <= 1'b0;
    end else begin
      cmd_rdata_o  <= next_rdata;
      cmd_rvalid_o <= next_rvalid;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Delayed start of frame generation.

  func_state_t fs_prev;
  logic        next_sof_wait;
  logic        next_sof_enable;
  logic        next_frame_set;

  assign sof_entry = (fs == bus_operational_state) && (fs_prev != bus_operational_state);

  // Leaving operational stops frames on the next clock edge, and the delay restarts on each entry.
  always_comb begin
    next_sof_wait   = sof_wait;
    next_sof_enable = sof_enable_o;
    next_frame_set  = 1'b0;
    if (fs != bus_operational_state) begin
      next_sof_wait   = 1'b0;
      next_sof_enable = 1'b0;
    end else if (sof_entry) begin
      next_sof_wait   = 1'b1;
      next_sof_enable = 1'b0;
    end else if (sof_wait && sof_tick) begin
      next_sof_wait   = 1'b0;
      next_sof_enable = 1'b1;
      next_frame_set  = 1'b1;
    end
  end

  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      fs_prev                <= bus_reset_state;
      sof_wait               <= 1'b0;
      sof_enable_o           <= 1'b0;
      frame_start_flag_set_o <= 1'b0;
    end else begin
      fs_prev                <= fs;
      sof_wait               <= next_sof_wait;
      sof_enable_o           <= next_sof_enable;
      frame_start_flag_set_o <= next_frame_set;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Hardware reset follow-up on the root hub and downstream ports.

  logic [MS_CNT_WIDTH-1:0] bus_ms;
  logic [MS_CNT_WIDTH-1:0] next_bus_ms;
  logic                    next_hub_reset;
  logic                    next_port_reset;

  // Software reset does not reach here: only the hardware reset loads these flops.
  always_comb begin
    next_hub_reset  = 1'b0;
    next_port_reset = port_bus_reset_o;
    next_bus_ms     = bus_ms;
    if (port_bus_reset_o && bus_tick) begin
      if (bus_ms == MS_CNT_WIDTH'(BUS_RESET_MS - 1)) begin
        next_port_reset = 1'b0;
        next_bus_ms     = '0;
      end else begin
        next_bus_ms = bus_ms + 1'b1;
      end
    end
  end

  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      root_hub_reset_o <= 1'b1;
      port_bus_reset_o <= 1'b1;
      bus_ms           <= '0;
    end else begin
      root_hub_reset_o <= next_hub_reset;
      port_bus_reset_o <= next_port_reset;
      bus_ms           <= next_bus_ms;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Status outputs.

  // The wake request is a separate output; the interrupt path never looks at the enable.
  assign remote_wakeup_o         = wake_en && resume_detect_flag_i;
  assign remote_wake_enable_o    = wake_en;
  assign remote_wake_connected_o = wake_conn;
  assign host_functional_state_o = fs;

endmodule
`default_nettype wire

// ---- sim/host_mode_assertions.sv ----
// Concurrent checks on the ports of the host operating-mode control block.
`timescale 1ns/1ps
`default_nettype none
module host_mode_checker #(
  parameter int CYCLES_PER_MS = 8,
  parameter int BUS_RESET_MS  = 2
) (
  input wire logic        clk_i,
  input wire logic        reset_n_i,
  input wire logic        cmd_valid_i,
  input wire logic [7:0]  cmd_code_i,
  input wire logic [31:0] cmd_rdata_o,
  input wire logic        cmd_rvalid_o,
  input wire logic        soft_reset_i,
  input wire logic        port_resume_i,
  input wire logic        resume_detect_flag_i,
  input wire logic        remote_wakeup_o,
  input wire logic        remote_wake_enable_o,
  input wire logic        remote_wake_connected_o,
  input wire logic [1:0]  host_functional_state_o,
  input wire logic        sof_enable_o,
  input wire logic        frame_start_flag_set_o,
  input wire logic        root_hub_reset_o,
  input wire logic        port_bus_reset_o
);
  logic        wr;
  logic [15:0] op_cnt, next_op_cnt, rel_cnt, next_rel_cnt;
  assign wr = cmd_valid_i && cmd_code_i == 8'h81;
  // Counters saturate so a long run never wraps into a false window.
  always_comb begin
    next_op_cnt  = (host_functional_state_o != 2'b10) ? 16'h0000 : op_cnt + 16'(op_cnt != 16'hFFFF);
    next_rel_cnt = rel_cnt + 16'(rel_cnt != 16'hFFFF);
  end
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      op_cnt  <= 16'h0000;
      rel_cnt <= 16'h0000;
    end else begin
      op_cnt  <= next_op_cnt;
      rel_cnt <= next_rel_cnt;
    end
  end
  //////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!reset_n_i);
  chk_read_answer: assert property (cmd_rvalid_o == $past(cmd_valid_i && cmd_code_i == 8'h01))
    else $error("read answer timing wrong");
  chk_reserved_zero: assert property (cmd_rvalid_o |-> (cmd_rdata_o & 32'hFFFF_F93F) == 32'h0000_0000)
    else $error("reserved bits read nonzero");
  chk_wake_hold: assert property (!wr && !soft_reset_i |=> $stable(remote_wake_enable_o))
    else $error("wake enable changed without write");
  chk_wakeup_out: assert property (remote_wakeup_o == (remote_wake_enable_o && resume_detect_flag_i))
    else $error("remote wakeup output wrong");
  chk_conn_keep: assert property (!wr |=> $stable(remote_wake_connected_o))
    else $error("wake connected changed without write");
  chk_hw_state_move: assert property (!$past(wr) && !$past(soft_reset_i) && !$stable(host_functional_state_o)
    |-> $past(host_functional_state_o) == 2'b11 && host_functional_state_o == 2'b01)
    else $error("state moved by hardware outside suspend");
  chk_resume_move: assert property (host_functional_state_o == 2'b11 && port_resume_i && !wr && !soft_reset_i
    |=> host_functional_state_o == 2'b01)
    else $error("resume not entered from suspend");
  chk_soft_state: assert property (soft_reset_i |=> host_functional_state_o == 2'b00)
    else $error("soft reset did not give reset state");
  chk_sof_delay: assert property ($rose(sof_enable_o) |-> op_cnt >= CYCLES_PER_MS && op_cnt <= CYCLES_PER_MS + 3)
    else $error("frames started at wrong time");
  chk_sof_bound: assert property (op_cnt == CYCLES_PER_MS + 4 |-> sof_enable_o)
    else $error("frames did not start");
  chk_sof_stop: assert property (host_functional_state_o != 2'b10 |=> !sof_enable_o)
    else $error("frames run outside operational");
  chk_hub_pulse: assert property ($rose(reset_n_i) |-> root_hub_reset_o ##[1:4] !root_hub_reset_o)
    else $error("root hub reset pulse wrong");
  chk_bus_reset_len: assert property (!port_bus_reset_o |-> rel_cnt >= BUS_RESET_MS * CYCLES_PER_MS)
    else $error("bus reset too short");
  chk_no_late_reset: assert property (!root_hub_reset_o && !port_bus_reset_o
    |=> !root_hub_reset_o && !port_bus_reset_o)
    else $error("hub or bus reset without hardware reset");
  cover property ($rose(sof_enable_o));
  cover property (host_functional_state_o == 2'b11 && port_resume_i);
  cover property (soft_reset_i);
endmodule
bind host_functional_state_control host_mode_checker #(.CYCLES_PER_MS(CYCLES_PER_MS), .BUS_RESET_MS(BUS_RESET_MS))
  u_chk (.*);
`default_nettype wire

// ---- sim/host_driver_model.sv ----
// Behavioural model of the host driver issuing mode register commands.
`timescale 1ns/1ps
`default_nettype none
module host_driver_model (
  input  wire logic        clk_i,
  output var  logic        cmd_valid_o,
  output var  logic [7:0]  cmd_code_o,
  output var  logic [31:0] cmd_wdata_o,
  input  wire logic [31:0] cmd_rdata_i,
  input  wire logic        cmd_rvalid_i
);
  initial begin
    cmd_valid_o = 1'b0;
    cmd_code_o  = 8'h00;
    cmd_wdata_o = 32'h0000_0000;
  end
  // Data is inverted when idle so a stale word is never mistaken for a fresh one.
  task automatic put(input logic [7:0] code, input logic [31:0] data);
    @(negedge clk_i);
    cmd_valid_o = 1'b1;
    cmd_code_o  = code;
    cmd_wdata_o = data;
    @(negedge clk_i);
    cmd_valid_o = 1'b0;
    cmd_wdata_o = ~data;
  endtask
  task automatic get(output logic [31:0] data, output logic ok);
    put(8'h01, 32'h0000_0000);
    ok   = cmd_rvalid_i;
    data = cmd_rdata_i;
  endtask
  task automatic rmw(input logic [31:0] keep, input logic [31:0] set);
    logic [31:0] v;
    logic        ok;
    get(v, ok);
    put(8'h81, (v & keep) | set);
  endtask
endmodule
`default_nettype wire

// ---- sim/host_functional_state_control_tb_top.sv ----
// Self-checking bench for the host operating-mode control block.
`timescale 1ns/1ps
`default_nettype none
module host_functional_state_control_tb_top;
  localparam int CPM = 8;
  localparam int BRM = 2;
  logic        clk_i, reset_n_i, cmd_valid_i, cmd_rvalid_o, soft_reset_i, port_resume_i, resume_detect_flag_i;
  logic        remote_wakeup_o, remote_wake_enable_o, remote_wake_connected_o, sof_enable_o, ok;
  logic        frame_start_flag_set_o, root_hub_reset_o, port_bus_reset_o;
  logic [1:0]  host_functional_state_o;
  logic [7:0]  cmd_code_i;
  logic [31:0] cmd_wdata_i, cmd_rdata_o, rd;
  int          fails = 0;
  int          tests_run = 0;
  host_functional_state_control #(.CYCLES_PER_MS(CPM), .BUS_RESET_MS(BRM)) u_dut (.*);
  host_driver_model u_host (.clk_i(clk_i), .cmd_valid_o(cmd_valid_i), .cmd_code_o(cmd_code_i),
    .cmd_wdata_o(cmd_wdata_i), .cmd_rdata_i(cmd_rdata_o), .cmd_rvalid_i(cmd_rvalid_o));
  initial begin
    clk_i = 1'b0;
    forever #10 clk_i = ~clk_i;
  end
  //////////////////////////////////////////////////////////////////////////////
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    tests_run++;
    if (got !== exp) begin
      fails++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic test_done;
    $display("checks %0d mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic hw_reset;
    reset_n_i = 1'b0;
    repeat (20) @(negedge clk_i);
    chk("hub and bus reset held", 32'h3, 32'({root_hub_reset_o, port_bus_reset_o}));
    reset_n_i = 1'b1;
    repeat (3) @(negedge clk_i);
    chk("hub reset released", 32'h0, 32'(root_hub_reset_o));
  endtask
  //////////////////////////////////////////////////////////////////////////////
  task automatic t_reset_values;
    chk("bus reset", 32'h1, 32'(port_bus_reset_o));
    u_host.get(rd, ok);
    chk("read answer", 32'h1, 32'(ok));
    chk("mode after reset", 32'h0000_0000, rd);
    repeat (BRM * CPM + 8) @(negedge clk_i);
    chk("hub and bus reset", 32'h0, 32'({root_hub_reset_o, port_bus_reset_o}));
  endtask
  task automatic t_reg_access;
    u_host.put(8'h81, 32'hFFFF_FFFF);
    u_host.put(8'h82, 32'h0000_0000);
    u_host.get(rd, ok);
    chk("mode all ones", 32'h0000_06C0, rd);
    chk("state suspend", 32'h3, 32'(host_functional_state_o));
  endtask
  task automatic t_wakeup;
    for (int i = 0; i < 4; i++) begin
      u_host.put(8'h81, 32'h0000_02C0 | (32'(i / 2) << 10));
      resume_detect_flag_i = i[0];
      #1;
      chk("remote wakeup", 32'(i == 3), 32'(remote_wakeup_o));
    end
  endtask
  task automatic t_resume;
    @(negedge clk_i);
    port_resume_i = 1'b1;
    @(negedge clk_i);
    chk("state resume", 32'h1, 32'(host_functional_state_o));
    @(negedge clk_i);
    port_resume_i = 1'b0;
    chk("state held", 32'h1, 32'(host_functional_state_o));
    chk("wake enable kept", 32'h1, 32'(remote_wake_enable_o));
  endtask
  task automatic t_frames;
    int n;
    n = 0;
    u_host.put(8'h81, 32'h0000_0080);
    while (frame_start_flag_set_o !== 1'b1 && n < 100) begin
      @(negedge clk_i);
      n++;
    end
    chk("frame delay ok", 32'h1, 32'(n >= CPM + 1 && n <= CPM + 3));
    chk("frames running", 32'h1, 32'(sof_enable_o));
    u_host.put(8'h81, 32'h0000_00C0);
    @(negedge clk_i);
    chk("frames stopped", 32'h0, 32'(sof_enable_o));
  endtask
  task automatic t_soft;
    u_host.rmw(32'hFFFF_FFFF, 32'h0000_0600);
    soft_reset_i = 1'b1;
    @(negedge clk_i);
    soft_reset_i = 1'b0;
    u_host.get(rd, ok);
    chk("mode after soft reset", 32'h0000_0200, rd);
    chk("wake connected kept", 32'h1, 32'(remote_wake_connected_o));
    chk("no hub or bus reset", 32'h0, 32'({root_hub_reset_o, port_bus_reset_o}));
  endtask
  task automatic t_hw_again;
    hw_reset;
    u_host.get(rd, ok);
    chk("mode after hw reset", 32'h0000_0000, rd);
    chk("wake connected cleared", 32'h0, 32'(remote_wake_connected_o));
  endtask
  //////////////////////////////////////////////////////////////////////////////
  initial begin
    reset_n_i = 1'b0;
    soft_reset_i = 1'b0;
    port_resume_i = 1'b0;
    resume_detect_flag_i = 1'b0;
    hw_reset;
    t_reset_values;
    t_reg_access;
    t_wakeup;
    t_resume;
    t_frames;
    t_soft;
    t_hw_again;
    test_done;
  end
  // The whole run needs well under a thousand cycles.
  initial begin
    #400_000;
    fails++;
    test_done;
  end
endmodule
`default_nettype wire
